// *** hw/clc_cfg.svh ***
// register offsets, field positions and reset values of the logic cell
`ifndef CLC_CFG_SVH
`define CLC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CLC_OFF_CTRL    8'h00
`define CLC_OFF_FLUT    8'h04
`define CLC_OFF_GLUT    8'h08
`define CLC_OFF_HLUT    8'h0c
`define CLC_OFF_STATUS  8'h10

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define CLC_ADDR_W      8
`define CLC_CTRL_W      15
`define CLC_LUT4_W      16
`define CLC_LUT3_W      8
`define CLC_CTRL_RST    15'h0000
`define CLC_LUT4_RST    16'h0000
`define CLC_LUT3_RST    8'h00

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define CLC_ST_QA       0
`define CLC_ST_QB       1
`define CLC_ST_X        2
`define CLC_ST_Y        3

`endif

// *** hw/clc_pkg.sv ***
// types shared by the logic cell design
package clc_pkg;

  // ram usage of the two look-up tables
  typedef enum logic [1:0] {
    CLC_RAM_OFF   = 2'h0,
    CLC_RAM_16X2  = 2'h1,
    CLC_RAM_32X1  = 2'h2,
    CLC_RAM_DP16  = 2'h3
  } clc_ram_e;

  // data source of a storage element
  typedef enum logic [1:0] {
    CLC_SRC_LUT   = 2'h0,
    CLC_SRC_COMB  = 2'h1,
    CLC_SRC_DIN   = 2'h2,
    CLC_SRC_HOLD  = 2'h3
  } clc_src_e;

  // control register layout, msb first
  typedef struct packed {
    logic     setB;
    logic     setA;
    logic     levelRam;
    clc_ram_e ramMode;
    logic     latchB;
    logic     latchA;
    clc_src_e srcB;
    clc_src_e srcA;
    logic     h2FromF;
    logic     h0FromG;
    logic     ySelH;
    logic     xSelH;
  } clc_ctrl_s;

  // apb answer carried back to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } clc_apb_rsp_s;

endpackage

// *** hw/clc_logic_cell.sv ***
// configurable logic cell: two 4-input tables, 3-input combiner, two storage elements
`timescale 1ns/1ns
`include "clc_cfg.svh"

module clc_logic_cell (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // apb configuration port
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`CLC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output clc_pkg::clc_apb_rsp_s         apbRsp,
  // cell inputs from the interconnect
  input  wire logic [3:0]               firstLutInputs,
  input  wire logic [3:0]               secondLutInputs,
  input  wire logic                     combinerFixedInput,
  input  wire logic                     combinerAltInputA,
  input  wire logic                     combinerAltInputB,
  input  wire logic                     directData,
  input  wire logic                     ramWriteDataA,
  input  wire logic                     ramWriteDataB,
  input  wire logic                     ramWriteEnable,
  input  wire logic                     cellClk,
  input  wire logic                     globalSetReset,
  // cell outputs to the interconnect
  output logic                          xOut,
  output logic                          yOut,
  output logic                          qA,
  output logic                          qB
);
  import clc_pkg::*;

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  clc_ctrl_s               ctrl;
  logic [`CLC_LUT4_W-1:0]  fLut;
  logic [`CLC_LUT4_W-1:0]  gLut;
  logic [`CLC_LUT3_W-1:0]  hLut;
  logic                    cellClkPrev;
  logic                    clkRise;
  logic                    fOut;
  logic                    gOut;
  logic                    hOut;
  logic [2:0]              hIdx;
  logic [3:0]              gRdAddr;
  logic [3:0]              gWrAddr;
  logic                    gWrData;
  logic                    ramOn;
  logic                    wrTime;
  logic                    fWr;
  logic                    gWr;
  logic                    apbAccess;
  logic                    apbWrite;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  assign apbAccess = psel && penable;
  assign apbWrite  = apbAccess && apbRsp.pready && pwrite;

  // read data and error selection by address
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `CLC_OFF_CTRL:   next_prdata[`CLC_CTRL_W-1:0] = ctrl;
      `CLC_OFF_FLUT:   next_prdata[`CLC_LUT4_W-1:0] = fLut;
      `CLC_OFF_GLUT:   next_prdata[`CLC_LUT4_W-1:0] = gLut;
      `CLC_OFF_HLUT:   next_prdata[`CLC_LUT3_W-1:0] = hLut;
      `CLC_OFF_STATUS: next_prdata[3:0] = {yOut, xOut, qB, qA};
      default:         next_pslverr = 1'b1;
    endcase
  end

  // answer register; pready pulses for one cycle per transfer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= apbAccess && !apbRsp.pready;
      if (apbAccess && !apbRsp.pready) begin
        apbRsp.prdata  <= next_prdata;
        apbRsp.pslverr <= next_pslverr;
      end
    end
  end

  // control register and combiner table, written only by configuration
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl <= clc_ctrl_s'(`CLC_CTRL_RST);
      hLut <= `CLC_LUT3_RST;
    end else if (apbWrite) begin
      if (paddr == `CLC_OFF_CTRL) begin
        ctrl <= clc_ctrl_s'(pwdata[`CLC_CTRL_W-1:0]);
      end
      if (paddr == `CLC_OFF_HLUT) begin
        hLut <= pwdata[`CLC_LUT3_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // function generators
  // ----------------------------------------------------------------
  // in 32x1 mode the second table reads at the first table's address
  assign gRdAddr = (ctrl.ramMode == CLC_RAM_32X1) ? firstLutInputs : secondLutInputs;
  assign fOut    = fLut[firstLutInputs];
  assign gOut    = gLut[gRdAddr];
  // combiner index {alt b or F', fixed, alt a or G'}
  assign hIdx    = {ctrl.h2FromF ? fOut : combinerAltInputB,
                    combinerFixedInput,
                    ctrl.h0FromG ? gOut : combinerAltInputA};
  assign hOut    = hLut[hIdx];

  // two combinational outputs leave the cell
  assign xOut = ctrl.xSelH ? hOut : fOut;
  assign yOut = ctrl.ySelH ? hOut : gOut;

  // ----------------------------------------------------------------
  // ram write path
  // ----------------------------------------------------------------
  // cell clock is sampled; its rising edge times edge-triggered writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cellClkPrev <= 1'b0;
    end else begin
      cellClkPrev <= cellClk;
    end
  end

  assign clkRise = cellClk && !cellClkPrev;
  assign ramOn   = (ctrl.ramMode != CLC_RAM_OFF);
  // level mode writes every cycle while enabled; dual-port is edge only
  assign wrTime  = (ctrl.levelRam && ctrl.ramMode != CLC_RAM_DP16) ? 1'b1 : clkRise;
  assign fWr     = ramOn && ramWriteEnable && wrTime &&
                   !(ctrl.ramMode == CLC_RAM_32X1 && combinerFixedInput);
  assign gWr     = ramOn && ramWriteEnable && wrTime &&
                   (ctrl.ramMode != CLC_RAM_32X1 || combinerFixedInput);
  assign gWrAddr = (ctrl.ramMode == CLC_RAM_16X2) ? secondLutInputs : firstLutInputs;
  assign gWrData = (ctrl.ramMode == CLC_RAM_16X2) ? ramWriteDataB : ramWriteDataA;

  // first table: configuration load, else ram write; gsr not involved
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fLut <= `CLC_LUT4_RST;
    end else if (apbWrite && paddr == `CLC_OFF_FLUT) begin
      fLut <= pwdata[`CLC_LUT4_W-1:0];
    end else if (fWr) begin
      fLut[firstLutInputs] <= ramWriteDataA;
    end
  end

  // second table: configuration load, else ram write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gLut <= `CLC_LUT4_RST;
    end else if (apbWrite && paddr == `CLC_OFF_GLUT) begin
      gLut <= pwdata[`CLC_LUT4_W-1:0];
    end else if (gWr) begin
      gLut[gWrAddr] <= gWrData;
    end
  end

  // ----------------------------------------------------------------
  // storage elements
  // ----------------------------------------------------------------
  logic [1:0] capture;
  logic [1:0] dIn;
  logic [1:0] qVec;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_store
      clc_src_e src;
      logic     latchMode;
      logic     setVal;
      logic     lutRes;
      assign src       = (s == 0) ? ctrl.srcA : ctrl.srcB;
      assign latchMode = (s == 0) ? ctrl.latchA : ctrl.latchB;
      assign setVal    = (s == 0) ? ctrl.setA : ctrl.setB;
      assign lutRes    = (s == 0) ? fOut : gOut;
      // latch follows while the clock is high, flip-flop takes the rising edge
      assign capture[s] = latchMode ? cellClk : clkRise;
      always_comb begin
        unique case (src)
          CLC_SRC_LUT:  dIn[s] = lutRes;
          CLC_SRC_COMB: dIn[s] = hOut;
          CLC_SRC_DIN:  dIn[s] = directData;
          CLC_SRC_HOLD: dIn[s] = qVec[s];
        endcase
      end
      // global set/reset forces the configured value
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          qVec[s] <= 1'b0;
        end else if (globalSetReset) begin
          qVec[s] <= setVal;
        end else if (capture[s]) begin
          qVec[s] <= dIn[s];
        end
      end
    end
  endgenerate

  assign qA = qVec[0];
  assign qB = qVec[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_gsr_sets_q: assert property (globalSetReset |=> qA == $past(ctrl.setA) && qB == $past(ctrl.setB))
    else $error("storage did not take set value on gsr");
  a_gsr_keeps_ram: assert property (globalSetReset && !fWr && !apbWrite |=> $stable(fLut))
    else $error("gsr disturbed table contents");
  a_comb_lookup: assert property (hOut == hLut[{ctrl.h2FromF ? fOut : combinerAltInputB,
                                   combinerFixedInput, ctrl.h0FromG ? gOut : combinerAltInputA}])
    else $error("combiner index wrong");
  a_edge_write: assert property (ctrl.ramMode == CLC_RAM_16X2 && !ctrl.levelRam && ramWriteEnable
                                 && clkRise && !apbWrite
                                 |=> fLut[$past(firstLutInputs)] == $past(ramWriteDataA))
    else $error("edge ram write lost");
  a_level_follow: assert property (ctrl.ramMode == CLC_RAM_16X2 && ctrl.levelRam && ramWriteEnable
                                   && !apbWrite |=> gLut[$past(secondLutInputs)] == $past(ramWriteDataB))
    else $error("level ram did not follow data");
  a_wide_select: assert property (ctrl.ramMode == CLC_RAM_32X1 && ramWriteEnable && clkRise
                                  && combinerFixedInput && !ctrl.levelRam && !apbWrite
                                  |=> $stable(fLut) && gLut[$past(firstLutInputs)] == $past(ramWriteDataA))
    else $error("32x1 write reached wrong table");
  a_dual_port: assert property (ctrl.ramMode == CLC_RAM_DP16 && ramWriteEnable && clkRise && !apbWrite
                                |=> fLut[$past(firstLutInputs)] == $past(ramWriteDataA)
                                    && gLut[$past(firstLutInputs)] == $past(ramWriteDataA))
    else $error("dual-port copies diverged");
  a_no_edge_hold: assert property (ctrl.ramMode == CLC_RAM_DP16 && !clkRise && !apbWrite ##1
                                   ctrl.ramMode == CLC_RAM_DP16 |-> $stable(gLut))
    else $error("dual-port wrote without clock edge");
  a_din_capture: assert property (!ctrl.latchA && ctrl.srcA == CLC_SRC_DIN && clkRise && !globalSetReset
                                  |=> qA == $past(directData))
    else $error("direct data not captured");
  a_latch_hold: assert property (ctrl.latchB && !cellClk && !globalSetReset |=> $stable(qB))
    else $error("latch changed while closed");
  a_apb_answer: assert property (psel && penable && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("apb answer not one cycle after access");

  c_edge_write: cover property (ctrl.ramMode == CLC_RAM_16X2 && ramWriteEnable && clkRise);
  c_latch_open: cover property (ctrl.latchA && cellClk ##1 ctrl.latchA && !cellClk);
  c_gsr_pulse:  cover property (globalSetReset ##1 !globalSetReset);

endmodule

// *** sim/clc_fabric_model.sv ***
// interconnect model: routed cell clock pulse with optional ram write enable
`timescale 1ns/1ns
module clc_fabric_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // request from the bench
  input  wire logic req,
  input  wire logic weOn,
  // routed signals into the cell, and a done flag back to the bench
  output logic      cellClk,
  output logic      ramWriteEnable,
  output logic      done
);
  logic [1:0] phase;
  // ----------------------------------------
  // pulse sequencer
  // ----------------------------------------
  // low, one high cycle, low again; the clock stands still between requests
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase          <= 2'h0;
      cellClk        <= 1'b0;
      ramWriteEnable <= 1'b0;
      done           <= 1'b0;
    end else begin
      done <= (phase == 2'h2);
      case (phase)
        2'h0: if (req) phase <= 2'h1;
        2'h1: begin
          cellClk        <= 1'b1;
          ramWriteEnable <= weOn;
          phase          <= 2'h2;
        end
        default: begin
          cellClk        <= 1'b0;
          ramWriteEnable <= 1'b0;
          phase          <= 2'h0;
        end
      endcase
    end
  end
endmodule

// *** sim/tb_top.sv ***
// self-checking bench of the logic cell
`timescale 1ns/1ns
`include "clc_cfg.svh"
module tb_top;
  import clc_pkg::*;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  clc_apb_rsp_s apbRsp;
  logic [3:0] firstLutInputs = 0, secondLutInputs = 0;
  logic combinerFixedInput = 0, combinerAltInputA = 0, combinerAltInputB = 0;
  logic directData = 0, ramWriteDataA = 0, ramWriteDataB = 0, globalSetReset = 0;
  logic ramWriteEnable, cellClk, done, req = 0, weOn = 0;
  logic xOut, yOut, qA, qB;
  logic [15:0] fTab = 16'h6996, gTab = 16'h8001;
  logic [7:0] hTab = 8'hb8;
  int n_mismatch = 0, num_checks = 0, cyc = 0;

  clc_logic_cell u_clc_logic_cell (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apbRsp(apbRsp), .firstLutInputs(firstLutInputs),
    .secondLutInputs(secondLutInputs), .combinerFixedInput(combinerFixedInput),
    .combinerAltInputA(combinerAltInputA), .combinerAltInputB(combinerAltInputB), .directData(directData),
    .ramWriteDataA(ramWriteDataA), .ramWriteDataB(ramWriteDataB), .ramWriteEnable(ramWriteEnable),
    .cellClk(cellClk), .globalSetReset(globalSetReset), .xOut(xOut), .yOut(yOut), .qA(qA), .qB(qB));
  clc_fabric_model u_clc_fabric_model (.mclk(mclk), .resetn(resetn), .req(req), .weOn(weOn),
    .cellClk(cellClk), .ramWriteEnable(ramWriteEnable), .done(done));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #20 mclk = ~mclk;
  // cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1);
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0);
  endtask
  // routed clock pulse through the fabric model; address and data stay put meanwhile
  task pulse(input logic w);
    @(posedge mclk);
    req <= 1;
    weOn <= w;
    @(posedge mclk);
    req <= 0;
    do begin
      @(posedge mclk);
    end while (done !== 1'b1);
    @(negedge mclk);
  endtask
  task hin(input logic [2:0] v);
    combinerAltInputB <= v[2];
    combinerFixedInput <= v[1];
    combinerAltInputA <= v[0];
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), 32'h0, r);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test reset done");
  endtask
  task t_lut();
    wr(`CLC_OFF_FLUT, {16'h0, fTab});
    wr(`CLC_OFF_GLUT, {16'h0, gTab});
    wr(`CLC_OFF_HLUT, {24'h0, hTab});
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      firstLutInputs <= i[3:0];
      secondLutInputs <= i[3:0];
      @(negedge mclk);
      chk(32'(xOut), 32'(fTab[i]));
      chk(32'(yOut), 32'(gTab[i]));
    end
    $display("test lut done");
  endtask
  task t_comb();
    wr(`CLC_OFF_CTRL, 32'h0003);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      hin(i[2:0]);
      @(negedge mclk);
      chk(32'({xOut, yOut}), 32'({2{hTab[i]}}));
    end
    wr(`CLC_OFF_CTRL, 32'h000f);
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      firstLutInputs <= i[3:0];
      secondLutInputs <= i[3:0] ^ 4'h5;
      combinerFixedInput <= i[4];
      @(negedge mclk);
      chk(32'(xOut), 32'(i[4] ? gTab[i[3:0] ^ 4'h5] : fTab[i[3:0]]));
    end
    $display("test comb done");
  endtask
  task t_store();
    logic [31:0] r;
    wr(`CLC_OFF_CTRL, 32'h2060);
    wr(`CLC_OFF_HLUT, 32'hcc);
    hin(3'b000);
    directData <= 1;
    pulse(1'b0);
    chk(32'({qA, qB}), 32'h2);
    @(posedge mclk);
    hin(3'b010);
    directData <= 0;
    pulse(1'b0);
    chk(32'({qA, qB}), 32'h1);
    rd(`CLC_OFF_STATUS, 32'h0, r);
    chk(r, 32'({gTab[secondLutInputs], fTab[firstLutInputs], 2'b10}));
    globalSetReset <= 1;
    @(posedge mclk);
    @(negedge mclk);
    chk(32'({qA, qB}), 32'h2);
    @(posedge mclk);
    globalSetReset <= 0;
    // both latches, b from direct data, a holding; set value b only
    wr(`CLC_OFF_CTRL, 32'h43b0);
    directData <= 1;
    pulse(1'b0);
    chk(32'({qA, qB}), 32'h3);
    @(posedge mclk);
    directData <= 0;
    @(posedge mclk);
    @(negedge mclk);
    chk(32'(qB), 32'h1);
    @(posedge mclk);
    globalSetReset <= 1;
    @(posedge mclk);
    @(negedge mclk);
    chk(32'({qA, qB}), 32'h1);
    @(posedge mclk);
    globalSetReset <= 0;
    $display("test store done");
  endtask
  task t_ram();
    logic [31:0] r;
    wr(`CLC_OFF_HLUT, {24'h0, hTab});
    wr(`CLC_OFF_CTRL, 32'h0400);
    firstLutInputs <= 4'h5;
    secondLutInputs <= 4'h9;
    ramWriteDataA <= 1;
    ramWriteDataB <= 1;
    pulse(1'b1);
    chk(32'({xOut, yOut}), 32'h3);
    @(posedge mclk);
    globalSetReset <= 1;
    @(posedge mclk);
    globalSetReset <= 0;
    rd(`CLC_OFF_FLUT, 32'h0, r);
    chk(r, 32'h69b6);
    rd(`CLC_OFF_GLUT, 32'h0, r);
    chk(r, 32'h8201);
    wr(`CLC_OFF_CTRL, 32'h1400);
    ramWriteDataA <= 0;
    ramWriteDataB <= 0;
    pulse(1'b1);
    rd(`CLC_OFF_FLUT, 32'h0, r);
    chk(r, 32'h6996);
    wr(`CLC_OFF_CTRL, 32'h080d);
    firstLutInputs <= 4'h3;
    secondLutInputs <= 4'h0;
    combinerFixedInput <= 1;
    ramWriteDataA <= 1;
    pulse(1'b1);
    chk(32'(xOut), 32'h1);
    @(posedge mclk);
    combinerFixedInput <= 0;
    @(negedge mclk);
    chk(32'(xOut), 32'h0);
    // dual port at a word that is zero in both tables, so both writes show
    wr(`CLC_OFF_CTRL, 32'h0c00);
    firstLutInputs <= 4'h5;
    secondLutInputs <= 4'h5;
    pulse(1'b1);
    chk(32'({xOut, yOut}), 32'h3);
    @(posedge mclk);
    secondLutInputs <= 4'h6;
    @(negedge mclk);
    chk(32'(yOut), 32'h0);
    rd(`CLC_OFF_GLUT, 32'h0, r);
    chk(r, 32'h8029);
    rd(`CLC_OFF_FLUT, 32'h0, r);
    chk(r, 32'h69b6);
    $display("test ram done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1;
    t_reset();
    t_lut();
    t_comb();
    t_store();
    t_ram();
    results();
  end
endmodule
